/* common/dag_map.svh */
// Register offsets, field positions and reset values of the debug authentication gate.
// Assumes a 12-bit APB byte address; every register is one aligned 32-bit word.
`ifndef DAG_MAP_SVH
`define DAG_MAP_SVH

// ****************************************
// Register offsets
// ****************************************
`define DAG_CTRL_OFS      12'h000
`define DAG_USER_OFS      12'h004
`define DAG_STAT_OFS      12'h008

// ****************************************
// Control register fields
// ****************************************
`define DAG_CTRL_W        3
`define DAG_CTRL_RST      3'h3
`define DAG_CTRL_CLK_BIT  0
`define DAG_CTRL_SEC_BIT  1
`define DAG_CTRL_HOLD_BIT 2

// ****************************************
// User permission register fields
// ****************************************
`define DAG_USER_W        2
`define DAG_USER_RST      2'h0

// ****************************************
// Status register fields
// ****************************************
`define DAG_STAT_AUTH_LSB 0
`define DAG_STAT_GRNT_LSB 4
`define DAG_STAT_CAPT_BIT 10
`define DAG_STAT_DEPR_BIT 16

// ****************************************
// Sampled enables and grants after reset
// ****************************************
`define DAG_AUTH_RST      4'h0
`define DAG_GRANT_RST     6'h00

`endif

/* common/dag_pkg.sv */
// Types shared by the debug authentication gate modules.
// Assumes dag_map.svh supplies all numeric constants.
package dag_pkg;

	// ****************************************
	// Authentication enables and grants
	// ****************************************
	typedef struct packed {
		logic sninv;
		logic sinv;
		logic ninv;
		logic inv;
	} dag_auth_t;

	typedef struct packed {
		logic su_ninv;
		logic su_inv;
		logic s_ninv;
		logic s_inv;
		logic ns_ninv;
		logic ns_inv;
	} dag_grant_t;

	// ****************************************
	// Software-visible settings
	// ****************************************
	typedef struct packed {
		logic hold_at_reset;
		logic secure_capable;
		logic clocked_mode;
	} dag_ctrl_t;

	typedef struct packed {
		logic user_secure_noninvasive_permit;
		logic user_secure_invasive_permit;
	} dag_user_t;

	typedef struct packed {
		logic [31:0] prdata;
		logic        pready;
		logic        pslverr;
	} dag_apb_rsp_t;

	// ****************************************
	// Module state
	// ****************************************
	typedef struct packed {
		dag_auth_t stage1;
		dag_auth_t stage2;
	} dag_sync_state_t;

	typedef struct packed {
		dag_ctrl_t    ctrl;
		dag_user_t    user;
		dag_auth_t    auth;
		dag_grant_t   grant;
		logic         auth_clock_prev;
		logic         captured;
		logic         deprecated_seen;
		dag_apb_rsp_t rsp;
	} dag_top_state_t;

endpackage

/* logic/dag_sync.sv */
// Two-stage synchroniser for the four authentication enables.
// Assumes the enables may change at any time relative to pclk.
`timescale 1ns/1ps
`include "dag_map.svh"

module dag_sync
	import dag_pkg::*;
(
	// Clock and reset
	input  wire logic      pclk,
	input  wire logic      presetn,
	// Enables in and out
	input  wire dag_auth_t d,
	output dag_auth_t      q
);

	dag_sync_state_t s_r;
	dag_sync_state_t s_nxt;

	// First stage feeds the second stage only
	always_comb begin
		s_nxt        = s_r;
		s_nxt.stage1 = d;
		s_nxt.stage2 = s_r.stage1;
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			s_r <= {`DAG_AUTH_RST, `DAG_AUTH_RST};
		end else begin
			s_r <= s_nxt;
		end
	end

	assign q = s_r.stage2;

endmodule

/* logic/dag_grant_calc.sv */
// Permission equations: turns the sampled enables into debug grants.
// Assumes its inputs are already stable in the pclk domain; purely combinational.
`timescale 1ns/1ps
`include "dag_map.svh"

module dag_grant_calc
	import dag_pkg::*;
(
	// Sampled enables and settings
	input  wire dag_auth_t  auth,
	input  wire logic       secure_capable,
	input  wire dag_user_t  user,
	// Resulting permissions
	output dag_grant_t      grant
);

	// Invasive permission implies the non-invasive one at the same level
	function automatic logic implied(input logic inv, input logic ninv);
		implied = inv | ninv;
	endfunction

	logic ns_inv;
	logic ns_ninv;
	logic s_inv;
	logic s_ninv;

	always_comb begin
		ns_inv  = auth.inv;
		ns_ninv = implied(auth.inv, auth.ninv);
		s_inv   = auth.inv & auth.sinv;
		s_ninv  = implied(s_inv, auth.sninv) & ns_ninv;
		grant   = '0;
		if (secure_capable) begin
			grant.ns_inv  = ns_inv;
			grant.ns_ninv = ns_ninv;
			grant.s_inv   = s_inv;
			grant.s_ninv  = s_ninv | s_inv;
			grant.su_inv  = s_inv | (ns_inv & user.user_secure_invasive_permit);
			grant.su_ninv = grant.s_ninv | grant.su_inv
				| (ns_ninv & user.user_secure_noninvasive_permit);
		end else begin
			grant.ns_inv  = ns_inv;
			grant.ns_ninv = ns_ninv;
		end
	end

endmodule

/* logic/dag_gate.sv */
// Debug authentication gate: samples the four authentication enables and grants debug levels.
// Assumes an APB3 master on pclk; auth_clock and, in clocked mode, the enables are synchronous to pclk.
`timescale 1ns/1ps
`include "dag_map.svh"

module dag_gate
	import dag_pkg::*;
(
	// APB clock and reset
	input  wire logic        pclk,
	input  wire logic        presetn,
	// APB slave
	input  wire logic [11:0] paddr,
	input  wire logic        psel,
	input  wire logic        penable,
	input  wire logic        pwrite,
	input  wire logic [31:0] pwdata,
	output logic [31:0]      prdata,
	output logic             pready,
	output logic             pslverr,
	// Authentication interface
	input  wire logic        auth_clock,
	input  wire logic        auth_reset_n_a,
	input  wire logic        invasive_enable,
	input  wire logic        noninvasive_enable,
	input  wire logic        secure_invasive_enable,
	input  wire logic        secure_noninvasive_enable,
	// Permissions to the debug logic
	output dag_grant_t       grant,
	output logic             deprecated_combination
);

	// ****************************************
	// State and wiring
	// ****************************************
	dag_top_state_t s_r;
	dag_top_state_t s_nxt;

	dag_auth_t  raw_auth;
	dag_auth_t  synced_auth;
	dag_grant_t calc_grant;

	assign raw_auth.inv   = invasive_enable;
	assign raw_auth.ninv  = noninvasive_enable;
	assign raw_auth.sinv  = secure_invasive_enable;
	assign raw_auth.sninv = secure_noninvasive_enable;

	// ****************************************
	// Unclocked path: asynchronous enables
	// ****************************************
	// Unclocked mode looks only at the second stage; clocked mode samples the raw enables
	dag_sync u_sync (
		.pclk    (pclk),
		.presetn (presetn),
		.d       (raw_auth),
		.q       (synced_auth)
	);

	// ****************************************
	// Permission equations
	// ****************************************
	dag_grant_calc u_calc (
		.auth           (s_r.auth),
		.secure_capable (s_r.ctrl.secure_capable),
		.user           (s_r.user),
		.grant          (calc_grant)
	);

	// ****************************************
	// Helpers
	// ****************************************
	// Secure enable high while the matching non-secure one is low
	function automatic logic is_deprecated(input dag_auth_t a);
		is_deprecated = (a.sinv & ~a.inv) | (a.sninv & ~a.ninv);
	endfunction

	function automatic logic hit(input logic [11:0] addr, input logic [11:0] ofs);
		hit = (addr == ofs);
	endfunction

	// ****************************************
	// Next-state logic
	// ****************************************
	logic      setup;
	logic      access;
	logic      auth_edge;
	logic      take_sample;
	dag_auth_t sample_src;

	always_comb begin
		s_nxt       = s_r;
		setup       = psel & ~penable;
		access      = psel & penable & s_r.rsp.pready;
		auth_edge   = auth_clock & ~s_r.auth_clock_prev;
		sample_src  = s_r.ctrl.clocked_mode ? raw_auth : synced_auth;

		s_nxt.auth_clock_prev = auth_clock;

		// A sample event: every auth_clock rise, or every cycle when unclocked
		take_sample = s_r.ctrl.clocked_mode ? auth_edge : 1'b1;
		// Hold mode takes no new sample while captured is set, so the value last sampled stays; slower but tamper-proof
		if (s_r.ctrl.hold_at_reset && s_r.captured) begin
			take_sample = 1'b0;
		end

		if (s_r.ctrl.clocked_mode && !auth_reset_n_a) begin
			// Interface reset denies everything until the next sample
			s_nxt.auth     = `DAG_AUTH_RST;
			s_nxt.captured = 1'b0;
		end else if (take_sample) begin
			s_nxt.auth     = sample_src;
			s_nxt.captured = 1'b1;
		end

		// Grants follow the equations one cycle after the sampled enables
		s_nxt.grant = calc_grant;
		// Belt and braces: the implications are enforced again on the final grants
		if (s_nxt.grant.ns_inv) begin
			s_nxt.grant.ns_ninv = 1'b1;
		end
		if (s_nxt.grant.s_inv) begin
			s_nxt.grant.s_ninv = 1'b1;
		end
		if (s_nxt.grant.su_inv) begin
			s_nxt.grant.su_ninv = 1'b1;
		end

		// ****************************************
		// APB register access
		// ****************************************
		// Answer one cycle after setup: zero wait states, pready from a flop
		s_nxt.rsp.pready  = setup;
		s_nxt.rsp.pslverr = 1'b0;
		s_nxt.rsp.prdata  = 32'h0000_0000;
		if (setup) begin
			if (hit(paddr, `DAG_CTRL_OFS)) begin
				s_nxt.rsp.prdata[`DAG_CTRL_W-1:0] = s_r.ctrl;
			end else if (hit(paddr, `DAG_USER_OFS)) begin
				s_nxt.rsp.prdata[`DAG_USER_W-1:0] = s_r.user;
			end else if (hit(paddr, `DAG_STAT_OFS)) begin
				s_nxt.rsp.prdata[`DAG_STAT_AUTH_LSB +: 4] = s_r.auth;
				s_nxt.rsp.prdata[`DAG_STAT_GRNT_LSB +: 6] = s_r.grant;
				s_nxt.rsp.prdata[`DAG_STAT_CAPT_BIT]      = s_r.captured;
				s_nxt.rsp.prdata[`DAG_STAT_DEPR_BIT]      = s_r.deprecated_seen;
			end else begin
				s_nxt.rsp.pslverr = 1'b1;
			end
			if (pwrite) begin
				s_nxt.rsp.prdata = 32'h0000_0000;
			end
		end else if (access) begin
			s_nxt.rsp.pready = 1'b0;
		end

		// Writes take effect at the edge that closes the access phase
		if (access && pwrite) begin
			if (hit(paddr, `DAG_CTRL_OFS)) begin
				s_nxt.ctrl = pwdata[`DAG_CTRL_W-1:0];
			end else if (hit(paddr, `DAG_USER_OFS)) begin
				s_nxt.user = pwdata[`DAG_USER_W-1:0];
			end else if (hit(paddr, `DAG_STAT_OFS) && pwdata[`DAG_STAT_DEPR_BIT]) begin
				s_nxt.deprecated_seen = 1'b0;
			end
		end

		// Sticky flag: a new event wins over a clear in the same cycle
		if (is_deprecated(s_r.auth)) begin
			s_nxt.deprecated_seen = 1'b1;
		end
	end

	// ****************************************
	// State register
	// ****************************************
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			s_r.ctrl            <= `DAG_CTRL_RST;
			s_r.user            <= `DAG_USER_RST;
			s_r.auth            <= `DAG_AUTH_RST;
			s_r.grant           <= `DAG_GRANT_RST;
			s_r.auth_clock_prev <= 1'b0;
			s_r.captured        <= 1'b0;
			s_r.deprecated_seen <= 1'b0;
			s_r.rsp             <= '0;
		end else begin
			s_r <= s_nxt;
		end
	end

	// ****************************************
	// Outputs, all straight from flops
	// ****************************************
	// Registers reached only by software need no gating by the enables
	assign prdata                 = s_r.rsp.prdata;
	assign pready                 = s_r.rsp.pready;
	assign pslverr                = s_r.rsp.pslverr;
	assign grant                  = s_r.grant;
	assign deprecated_combination = s_r.deprecated_seen;

endmodule

/* tb/dag_monitor.sv */
// Checker of the gate's ports: grant relations, sticky flag and APB timing.
// Assumes it is bound onto dag_gate; one clock domain, pclk.
`timescale 1ns/1ps

module dag_monitor
	import dag_pkg::*;
(
	// Clock and reset
	input wire logic        pclk,
	input wire logic        presetn,
	// APB
	input wire logic [11:0] paddr,
	input wire logic        psel,
	input wire logic        penable,
	input wire logic        pwrite,
	input wire logic        pready,
	input wire logic        pslverr,
	// Permissions
	input wire dag_grant_t  grant,
	input wire logic        deprecated_combination
);
	default clocking cb @(posedge pclk);
	endclocking
	default disable iff (!presetn);

	// ********
	// APB phases
	// ********
	sequence s_setup;
		psel && !penable;
	endsequence
	sequence s_access;
		psel && penable && pready;
	endsequence

	property p_ready;
		s_setup |=> s_access;
	endproperty
	a_ready: assert property (p_ready) else $error("no ready after setup");
	property p_pulse;
		pready |=> !pready;
	endproperty
	a_pulse: assert property (p_pulse) else $error("ready longer than one cycle");
	property p_err;
		s_setup and (paddr[1:0] == 2'h0) |=> pslverr == (paddr > 12'h008);
	endproperty
	a_err: assert property (p_err) else $error("wrong error response");
	// Only a write to the status word may drop the flag
	property p_dep;
		deprecated_combination && !(psel && penable && pready && pwrite && paddr == 12'h008)
			|=> deprecated_combination;
	endproperty
	a_dep: assert property (p_dep) else $error("flag dropped");

	// ********
	// Grant relations
	// ********
	property p_implied;
		(grant.ns_inv <= grant.ns_ninv) && (grant.s_inv <= grant.s_ninv) && (grant.su_inv <= grant.su_ninv);
	endproperty
	a_implied: assert property (p_implied) else $error("invasive without non-invasive");
	property p_sinv;
		grant.s_inv |-> grant.ns_inv;
	endproperty
	a_sinv: assert property (p_sinv) else $error("secure invasive alone");
	property p_sninv;
		grant.s_ninv |-> grant.ns_ninv;
	endproperty
	a_sninv: assert property (p_sninv) else $error("secure trace alone");
	property p_user;
		grant.su_inv |-> grant.ns_inv;
	endproperty
	a_user: assert property (p_user) else $error("user level unbounded");
	property p_none;
		!grant.ns_ninv |-> grant == 6'h00;
	endproperty
	a_none: assert property (p_none) else $error("debug without enables");
endmodule

bind dag_gate dag_monitor dag_monitor_i (.pclk, .presetn, .paddr, .psel, .penable, .pwrite, .pready,
	.pslverr, .grant, .deprecated_combination);

/* tb/dag_auth_src.sv */
// Model of the system control that drives the authentication enables.
// Assumes requests arrive just after a pclk edge; auth_clock stays low between frames.
`timescale 1ns/1ps

module dag_auth_src
	import dag_pkg::*;
(
	// Clock
	input wire logic      pclk,
	// Requests
	input wire dag_auth_t want,
	input wire logic      go,
	input wire logic      quiet,
	// Authentication interface
	output logic          auth_clock,
	output dag_auth_t     en
);
	logic stage = 1'b0;

	initial begin
		auth_clock = 1'b0;
		en = 4'h0;
	end
	// Enables settle one cycle before the clock edge that samples them
	always @(posedge pclk) begin
		stage <= go;
		auth_clock <= stage & !quiet;
		if (go)
			en <= want;
	end
endmodule

/* tb/dag_gate_tb.sv */
// Bench for the gate: table of enable patterns, then reset, refusal, hold and unclocked cases.
// Assumes dag_gate, its map header and the partner model dag_auth_src.
`timescale 1ns/1ps
`include "dag_map.svh"

module dag_gate_tb
	import dag_pkg::*;
;
	logic        pclk = 1'b0;
	logic        presetn = 1'b0;
	logic        psel = 1'b0;
	logic        penable = 1'b0;
	logic        pwrite = 1'b0;
	logic        auth_reset_n_a = 1'b1;
	logic        go = 1'b0;
	logic        quiet = 1'b0;
	logic        pready;
	logic        pslverr;
	logic        auth_clock;
	logic        deprecated_combination;
	logic        err;
	logic        dep_x = 1'b0;
	logic [11:0] paddr = 12'h000;
	logic [31:0] pwdata = 32'h0;
	logic [31:0] prdata;
	logic [31:0] rd;
	logic [6:0]  r;
	dag_auth_t   want = 4'h0;
	dag_auth_t   en;
	dag_grant_t  g;
	dag_grant_t  grant;
	int          bad_count = 0;
	int          checks = 0;
	int          cyc = 0;
	// Row: secure capable, user permits, enables
	logic [6:0]  rows [24] = '{7'h40, 7'h41, 7'h42, 7'h43, 7'h44, 7'h45, 7'h46, 7'h47, 7'h48, 7'h49, 7'h4A,
		7'h4B, 7'h4C, 7'h4D, 7'h4E, 7'h4F, 7'h03, 7'h05, 7'h0F, 7'h0A, 7'h51, 7'h62, 7'h7D, 7'h60};

	dag_gate dag_gate_i (.pclk, .presetn, .paddr, .psel, .penable, .pwrite, .pwdata, .prdata, .pready,
		.pslverr, .auth_clock, .auth_reset_n_a, .invasive_enable(en.inv), .noninvasive_enable(en.ninv),
		.secure_invasive_enable(en.sinv), .secure_noninvasive_enable(en.sninv), .grant,
		.deprecated_combination);
	dag_auth_src dag_auth_src_i (.pclk, .want, .go, .quiet, .auth_clock, .en);

	always #50 pclk = ~pclk;

	// ********
	// Helpers
	// ********
	function automatic dag_grant_t ex(input dag_auth_t a, input logic s, input dag_user_t u);
		dag_grant_t x;
		x.ns_inv = a.inv;
		x.ns_ninv = a.inv | a.ninv;
		x.s_inv = s & a.inv & a.sinv;
		x.s_ninv = s & ((a.sinv & a.inv) | a.sninv) & x.ns_ninv;
		x.su_inv = s & (x.s_inv | (a.inv & u.user_secure_invasive_permit));
		x.su_ninv = s & (x.s_ninv | x.su_inv | (x.ns_ninv & u.user_secure_noninvasive_permit));
		return x;
	endfunction
	task chk(input string n, input logic [31:0] s, input logic [31:0] e);
		checks++;
		if (s !== e) begin
			bad_count++;
			$display("BAD %s expected %h seen %h", n, e, s);
		end
	endtask
	task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		do
			@(posedge pclk);
		while (pready !== 1'b1);
		rd = prdata;
		err = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		// Idle edge so the next call never re-raises psel in this time step
		@(posedge pclk);
	endtask
	task smp(input dag_auth_t a);
		want <= a;
		go <= 1'b1;
		@(posedge pclk);
		go <= 1'b0;
		repeat (5) @(posedge pclk);
	endtask
	task results;
		if (bad_count == 0 && checks > 0)
			$display("DONE - PASS");
		else
			$display("DONE - FAIL");
		$finish;
	endtask

	always @(posedge pclk) begin
		cyc <= cyc + 1;
		if (cyc == 2000) begin
			bad_count++;
			results();
		end
	end

	// ********
	// Sequence
	// ********
	initial begin
		repeat (12) @(posedge pclk);
		presetn <= 1'b1;
		@(posedge pclk);
		foreach (rows[i]) begin
			r = rows[i];
			apb(1'b1, `DAG_CTRL_OFS, {30'h0, r[6], 1'b1});
			apb(1'b1, `DAG_USER_OFS, {30'h0, r[5:4]});
			smp(r[3:0]);
			g = ex(r[3:0], r[6], r[5:4]);
			dep_x = dep_x | (r[2] & ~r[0]) | (r[3] & ~r[1]);
			chk("grant", grant, g);
			chk("dep", deprecated_combination, dep_x);
			apb(1'b0, `DAG_STAT_OFS, 32'h0);
			chk("status", rd, {15'h0, dep_x, 5'h0, 1'b1, g, r[3:0]});
		end
		presetn <= 1'b0;
		repeat (2) @(posedge pclk);
		presetn <= 1'b1;
		@(posedge pclk);
		chk("grant", grant, 32'h0);
		apb(1'b0, `DAG_CTRL_OFS, 32'h0);
		chk("ctrl", rd, 32'h3);
		apb(1'b0, `DAG_USER_OFS, 32'h0);
		chk("user", rd, 32'h0);
		apb(1'b0, `DAG_STAT_OFS, 32'h0);
		chk("status", rd, 32'h0);
		apb(1'b1, 12'h00C, 32'hFFFFFFFF);
		chk("err", err, 1'b1);
		apb(1'b0, 12'h00C, 32'h0);
		chk("unmapped", rd, 32'h0);
		chk("err", err, 1'b1);
		smp(4'h4);
		smp(4'h0);
		chk("dep", deprecated_combination, 1'b1);
		apb(1'b1, `DAG_STAT_OFS, 32'hFFFFFFFF);
		apb(1'b0, `DAG_STAT_OFS, 32'h0);
		chk("status", rd, 32'h400);
		// Enables move with no clock edge: clocked mode must not see them
		quiet <= 1'b1;
		smp(4'hF);
		chk("grant", grant, 32'h0);
		apb(1'b1, `DAG_CTRL_OFS, 32'h7);
		quiet <= 1'b0;
		auth_reset_n_a <= 1'b0;
		repeat (3) @(posedge pclk);
		auth_reset_n_a <= 1'b1;
		smp(4'hF);
		chk("grant", grant, 32'h3F);
		smp(4'h0);
		chk("grant", grant, 32'h3F);
		auth_reset_n_a <= 1'b0;
		repeat (3) @(posedge pclk);
		chk("grant", grant, 32'h0);
		auth_reset_n_a <= 1'b1;
		apb(1'b1, `DAG_CTRL_OFS, 32'h2);
		quiet <= 1'b1;
		smp(4'h7);
		chk("grant", grant, ex(4'h7, 1'b1, 2'h0));
		results();
	end
endmodule
